// ===== logic/rcdim_consts.svh
// Offsets, field positions, reset values and index codes for the dest/dim regs
`ifndef RCDIM_CONSTS_SVH
`define RCDIM_CONSTS_SVH

// ****************************************************************
// Register indices and address width
// ****************************************************************
`define RCDIM_IDX_DEST_LOW 4'h4
`define RCDIM_IDX_DEST_HIGH 4'h5
`define RCDIM_IDX_DIM_X 4'h6
`define RCDIM_IDX_DIM_Y 4'h7
`define RCDIM_IDX_CTRL 4'hC
`define RCDIM_IDX_STATUS 4'hD
`define RCDIM_ADDR_W 6

// ****************************************************************
// Field positions
// ****************************************************************
`define RCDIM_IDX_HI 15
`define RCDIM_IDX_LO 12
`define RCDIM_LOW_W 12
`define RCDIM_HIGH_W 9
`define RCDIM_POS_W 21
`define RCDIM_DIM_W 12
`define RCDIM_DELTA_W 10
`define RCDIM_LOC_W 19
`define RCDIM_CTRL_W 8
`define RCDIM_CTRL_GO 0
`define RCDIM_ST_BUSY 0
`define RCDIM_ST_DIMOK 1
`define RCDIM_DIM_MAX 12'h800

// ****************************************************************
// Reset values
// ****************************************************************
`define RCDIM_RST_POS 21'h000000
`define RCDIM_RST_DIM 12'h000
`define RCDIM_RST_CTRL 8'h00

`endif

// ===== logic/rcdim_pkg.sv
// Types shared by the dest/dim register bank and its address mapper
package rcdim_pkg;

  // Control word, bit 0 is the write-only start request
  typedef struct packed {
    logic dest_linear;
    logic dest_is_mem;
    logic text_mode;
    logic packed_mode;
    logic line_mode;
    logic update_dest;
    logic quick_start;
    logic go;
  } rcdim_ctrl_t;

  // Where a position lands in display memory
  typedef struct packed {
    logic [18:0] location;
    logic [2:0] pixel_bit;
    logic [1:0] map_sel;
  } rcdim_map_t;

  typedef enum logic [1:0] {
    RCDIM_BUS_IDLE,
    RCDIM_BUS_ANSWER
  } rcdim_bus_t;

endpackage

// ===== logic/rcdim_addr_map.sv
// Turns a 21-bit position into location, pixel bit and map
`timescale 1ns/1ns
`default_nettype none
`include "rcdim_consts.svh"

module rcdim_addr_map (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [20:0] pos,
  input wire logic packed_mode,
  output rcdim_pkg::rcdim_map_t map_q
);
  import rcdim_pkg::*;

  // ****************************************************************
  // Decode
  // ****************************************************************
  // Location is a byte offset, pages counted as contiguous
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      map_q <= '0;
    end else if (packed_mode) begin
      map_q.location <= {1'b0, pos[19:2]};
      map_q.pixel_bit <= 3'h0;
      map_q.map_sel <= pos[1:0];
    end else begin
      map_q.location <= {1'b0, pos[20:3]};
      map_q.pixel_bit <= 3'h7 - pos[2:0];
      map_q.map_sel <= 2'h0;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_planar_bit: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !packed_mode |=> map_q.pixel_bit == 3'h7 - $past(pos[2:0])
      && map_q.location == {1'b0, $past(pos[20:3])})
    else $error("planar pixel bit or location wrong");
  a_packed_map: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    packed_mode |=> map_q.map_sel == $past(pos[1:0])
      && map_q.location == {1'b0, $past(pos[19:2])})
    else $error("packed map or location wrong");

endmodule // rcdim_addr_map

`default_nettype wire

// ===== logic/rcdim_regs.sv
// Destination position and dimension register bank on Avalon-MM
//
// Behaviour
// - Index 4 write loads position bits 11:0
// - Index 5 write loads bits 20:12; reserved zero
// - Position names starting corner of the move
// - Planar: low three bits pick pixel bit
// - Packed: low two bits pick map
// - Location is contiguous byte offset in memory
// - Non-memory destination ignores position pair
// - Width register, software keeps 1 to 2K
// - Graphics pixels; text characters times eight
// - Line mode: X delta uses bits 9:0
// - Height register, 1 to 2K, pixels or rows
// - Line mode: Y delta uses bits 9:0
// - Low and high concatenate to 21 bits
// - Quick start, update off: dest-low write starts transfer
// - Update on: advance destination after transfer
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "rcdim_consts.svh"

module rcdim_regs (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic engine_done,
  output logic engine_start,
  output rcdim_pkg::rcdim_ctrl_t engine_ctrl,
  output logic [20:0] dest_pos,
  output logic dest_valid,
  output logic [11:0] dim_x,
  output logic [11:0] dim_y,
  output logic [9:0] line_delta_x,
  output logic [9:0] line_delta_y,
  output rcdim_pkg::rcdim_map_t dest_map
);
  import rcdim_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // A write lands only on its own index code in bits 15:12
  function automatic logic idx_hit(input logic [5:0] addr,
                                   input logic [31:0] data,
                                   input logic [3:0] code);
    idx_hit = (addr[5:2] == code)
      && (data[`RCDIM_IDX_HI:`RCDIM_IDX_LO] == code);
  endfunction

  function automatic logic dim_legal(input logic [11:0] d);
    dim_legal = (d != `RCDIM_RST_DIM) && (d <= `RCDIM_DIM_MAX);
  endfunction

  // ****************************************************************
  // Bus handshake
  // ****************************************************************
  rcdim_bus_t bus_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic wr_ok;
  logic rd_take;
  logic lanes_ok;

  // One wait cycle, then the request completes
  assign rd_take = avs_read && (bus_q == RCDIM_BUS_IDLE);
  assign lanes_ok = avs_byteenable[1:0] == 2'h3;
  assign wr_ok = avs_write && !wait_q && lanes_ok;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bus_q <= RCDIM_BUS_IDLE;
      wait_q <= 1'b1;
    end else begin
      unique case (bus_q)
        RCDIM_BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_q <= RCDIM_BUS_ANSWER;
            wait_q <= 1'b0;
          end
        end
        RCDIM_BUS_ANSWER: begin
          bus_q <= RCDIM_BUS_IDLE;
          wait_q <= 1'b1;
        end
      endcase
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [20:0] dest_q;
  logic [20:0] dest_d;
  logic [11:0] dim_x_q;
  logic [11:0] dim_y_q;
  rcdim_ctrl_t ctrl_q;
  logic busy_q;
  logic start_q;
  logic wr_low;
  logic wr_high;
  logic wr_ctrl;
  logic soft_go;
  logic quick_go;
  logic [20:0] advance;

  assign wr_low = wr_ok && idx_hit(avs_address, avs_writedata,
    `RCDIM_IDX_DEST_LOW);
  assign wr_high = wr_ok && idx_hit(avs_address, avs_writedata,
    `RCDIM_IDX_DEST_HIGH);
  assign wr_ctrl = wr_ok && idx_hit(avs_address, avs_writedata,
    `RCDIM_IDX_CTRL);
  assign soft_go = wr_ctrl && avs_writedata[`RCDIM_CTRL_GO];
  assign quick_go = wr_low && ctrl_q.quick_start && !ctrl_q.update_dest;

  // Linear regions advance by the whole area, rectangles by one width
  always_comb begin
    if (ctrl_q.dest_linear) begin
      advance = 21'(dim_x_q * dim_y_q);
    end else begin
      advance = {9'h000, dim_x_q};
    end
  end

  // Software write beats the end-of-transfer update in the same cycle, for the field it writes
  always_comb begin
    dest_d = dest_q;
    if (engine_done && ctrl_q.update_dest) begin
      dest_d = 21'(dest_q + advance);
    end
    if (wr_low) begin
      dest_d[11:0] = avs_writedata[11:0];
    end
    if (wr_high) begin
      dest_d[20:12] = avs_writedata[8:0];
    end
  end

  // Position is the start corner; corner vs direction is software's
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dest_q <= `RCDIM_RST_POS;
    end else begin
      dest_q <= dest_d;
    end
  end

  // Width in pixels or characters x8; the engine reads it per mode
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dim_x_q <= `RCDIM_RST_DIM;
      dim_y_q <= `RCDIM_RST_DIM;
    end else begin
      if (wr_ok && idx_hit(avs_address, avs_writedata,
          `RCDIM_IDX_DIM_X)) begin
        dim_x_q <= avs_writedata[11:0];
      end
      if (wr_ok && idx_hit(avs_address, avs_writedata,
          `RCDIM_IDX_DIM_Y)) begin
        dim_y_q <= avs_writedata[11:0];
      end
    end
  end

  // Go bit is never stored; busy reflects it instead
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_q <= `RCDIM_RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl_q <= {avs_writedata[7:1], 1'b0};
    end
  end

  // ****************************************************************
  // Start and busy
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      start_q <= 1'b0;
    end else begin
      start_q <= soft_go || quick_go;
    end
  end

  // A new start in the done cycle keeps busy set
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
    end else if (soft_go || quick_go) begin
      busy_q <= 1'b1;
    end else if (engine_done) begin
      busy_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdata_q <= 32'h00000000;
    end else if (rd_take) begin
      unique case (avs_address[5:2])
        `RCDIM_IDX_DEST_LOW:
          rdata_q <= {16'h0000, `RCDIM_IDX_DEST_LOW, dest_q[11:0]};
        `RCDIM_IDX_DEST_HIGH:
          rdata_q <= {16'h0000, `RCDIM_IDX_DEST_HIGH, 3'h0, dest_q[20:12]};
        `RCDIM_IDX_DIM_X:
          rdata_q <= {16'h0000, `RCDIM_IDX_DIM_X, dim_x_q};
        `RCDIM_IDX_DIM_Y:
          rdata_q <= {16'h0000, `RCDIM_IDX_DIM_Y, dim_y_q};
        `RCDIM_IDX_CTRL:
          rdata_q <= {16'h0000, `RCDIM_IDX_CTRL, 4'h0, ctrl_q};
        `RCDIM_IDX_STATUS:
          rdata_q <= {16'h0000, `RCDIM_IDX_STATUS, 10'h000,
            dim_legal(dim_x_q) && dim_legal(dim_y_q), busy_q};
        default:
          rdata_q <= 32'h00000000;
      endcase
    end
  end

  // ****************************************************************
  // Engine side outputs
  // ****************************************************************
  logic [9:0] dx_q;
  logic [9:0] dy_q;
  logic dest_valid_q;

  // Line mode hands over only the low ten bits as deltas
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dx_q <= 10'h000;
      dy_q <= 10'h000;
    end else begin
      dx_q <= ctrl_q.line_mode ? dim_x_q[9:0] : 10'h000;
      dy_q <= ctrl_q.line_mode ? dim_y_q[9:0] : 10'h000;
    end
  end

  // Position pair means nothing unless the target is display memory
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dest_valid_q <= 1'b0;
    end else begin
      dest_valid_q <= ctrl_q.dest_is_mem;
    end
  end

  rcdim_addr_map u_map (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pos(dest_q),
    .packed_mode(ctrl_q.packed_mode),
    .map_q(dest_map)
  );

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign engine_start = start_q;
  assign engine_ctrl = ctrl_q;
  assign dest_pos = dest_q;
  assign dest_valid = dest_valid_q;
  assign dim_x = dim_x_q;
  assign dim_y = dim_y_q;
  assign line_delta_x = dx_q;
  assign line_delta_y = dy_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_low_store: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    wr_low |=> dest_q[11:0] == $past(avs_writedata[11:0]))
    else $error("dest low not stored");
  a_high_store: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    wr_high |=> dest_q[20:12] == $past(avs_writedata[8:0]))
    else $error("dest high not stored");
  a_quick_start: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    quick_go |=> start_q && busy_q)
    else $error("quick start missed");
  a_no_quick_upd: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    wr_low && ctrl_q.update_dest && !wr_ctrl |=> !start_q)
    else $error("start with update on");
  a_start_cause: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !(soft_go || quick_go) |=> !start_q)
    else $error("start without request");
  a_busy_clear: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    engine_done && !soft_go && !quick_go |=> !busy_q)
    else $error("busy not cleared");
  a_dest_advance: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    engine_done && ctrl_q.update_dest && !ctrl_q.dest_linear
      && !wr_low && !wr_high
      |=> dest_q == 21'($past(dest_q) + {9'h000, $past(dim_x_q)}))
    else $error("dest not advanced");
  a_lin_advance: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    engine_done && ctrl_q.update_dest && ctrl_q.dest_linear
      && !wr_low && !wr_high
      |=> dest_q == 21'($past(dest_q)
        + 21'($past(dim_x_q) * $past(dim_y_q))))
    else $error("linear dest not advanced");
  a_dest_hold: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !wr_low && !wr_high && !(engine_done && ctrl_q.update_dest)
      |=> $stable(dest_q))
    else $error("dest changed unasked");
  a_dim_x_store: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    wr_ok && idx_hit(avs_address, avs_writedata, `RCDIM_IDX_DIM_X)
      |=> dim_x_q == $past(avs_writedata[11:0]))
    else $error("width not stored");
  a_dim_y_store: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    wr_ok && idx_hit(avs_address, avs_writedata, `RCDIM_IDX_DIM_Y)
      |=> dim_y_q == $past(avs_writedata[11:0]))
    else $error("height not stored");
  a_delta_x: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    ctrl_q.line_mode ##1 $stable(dim_x_q) |-> dx_q == dim_x_q[9:0])
    else $error("x delta wrong");
  a_delta_y: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    ctrl_q.line_mode ##1 $stable(dim_y_q) |-> dy_q == dim_y_q[9:0])
    else $error("y delta wrong");
  a_not_mem: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !ctrl_q.dest_is_mem |=> !dest_valid_q)
    else $error("dest valid off memory");
  a_bus_answer: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (avs_read || avs_write) && wait_q |=> !wait_q ##1 wait_q)
    else $error("bus answer late");

endmodule // rcdim_regs

`default_nettype wire

// ===== verif/rcdim_testbench.sv
// Self-checking testbench for the destination position and dimension bank
`timescale 1ns/1ns
`default_nettype none

`define CHK(what, exp, got) begin cmp_count++; if ((got) !== (exp)) begin \
  failures++; $display("MISMATCH %s expected %h seen %h", what, exp, got); \
  end end

module testbench;
  import rcdim_pkg::*;

  logic sys_clk;
  logic rst_n;
  logic [5:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic engine_done;
  logic engine_start;
  rcdim_ctrl_t engine_ctrl;
  logic [20:0] dest_pos;
  logic dest_valid;
  logic [11:0] dim_x;
  logic [11:0] dim_y;
  logic [9:0] line_delta_x;
  logic [9:0] line_delta_y;
  rcdim_map_t dest_map;
  int failures = 0;
  int cmp_count = 0;
  int starts = 0;
  logic [31:0] rd;
  localparam logic [20:0] POS = 21'h05AABD;

  rcdim_regs rcdim_regs_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .engine_done(engine_done), .engine_start(engine_start),
    .engine_ctrl(engine_ctrl), .dest_pos(dest_pos),
    .dest_valid(dest_valid), .dim_x(dim_x), .dim_y(dim_y),
    .line_delta_x(line_delta_x), .line_delta_y(line_delta_y),
    .dest_map(dest_map)
  );

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Counts start pulses so one-cycle strobes are never missed
  always @(posedge sys_clk) begin
    if (engine_start === 1'b1) starts++;
  end

  // ****************************************************************
  // Bus and run control
  // ****************************************************************
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic wait_ack();
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) begin
      failures++;
      $display("MISMATCH bus_timeout expected 0 seen 1");
      close_out();
    end
  endtask

  task automatic bus_wr(input logic [5:0] a, input logic [15:0] d,
                        input logic [3:0] be = 4'hF);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_byteenable <= be;
    avs_write <= 1'b1;
    wait_ack();
    avs_write <= 1'b0;
    // One idle edge so the strobe is never assigned twice at once
    @(posedge sys_clk);
  endtask

  task automatic bus_rd(input logic [5:0] a, output logic [31:0] d);
    avs_address <= a;
    avs_read <= 1'b1;
    wait_ack();
    d = avs_readdata;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic pulse_done();
    engine_done <= 1'b1;
    @(posedge sys_clk);
    engine_done <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset_and_pos();
    bus_rd(6'h10, rd);
    `CHK("low_reset", 32'h00004000, rd)
    bus_wr(6'h10, 16'h4ABD);
    bus_wr(6'h14, 16'h505A);
    `CHK("dest_pos", POS, dest_pos)
    bus_rd(6'h14, rd);
    `CHK("high_read", 32'h0000505A, rd)
    // Wrong code, lanes missing, unmapped place: all ignored
    bus_wr(6'h10, 16'h6123);
    bus_wr(6'h10, 16'h4123, 4'hC);
    bus_wr(6'h3C, 16'hF123);
    `CHK("refused", POS, dest_pos)
    bus_rd(6'h3C, rd);
    `CHK("unmapped", 32'h00000000, rd)
  endtask

  task automatic t_map();
    bus_wr(6'h30, 16'hC060);
    repeat (2) @(posedge sys_clk);
    `CHK("ctrl_out", 8'h60, engine_ctrl)
    `CHK("planar", {1'b0, POS[20:3], 3'h7 - POS[2:0], 2'h0}, dest_map)
    `CHK("valid_on", 1'b1, dest_valid)
    bus_wr(6'h30, 16'hC010);
    repeat (2) @(posedge sys_clk);
    `CHK("packed", {1'b0, POS[19:2], 3'h0, POS[1:0]}, dest_map)
    `CHK("valid_off", 1'b0, dest_valid)
  endtask

  task automatic t_dims();
    bus_wr(6'h30, 16'hC008);
    bus_wr(6'h18, 16'h6FFF);
    bus_wr(6'h1C, 16'h7255);
    @(posedge sys_clk);
    `CHK("dim_x", 12'hFFF, dim_x)
    `CHK("dim_y", 12'h255, dim_y)
    `CHK("delta_x", 10'h3FF, line_delta_x)
    `CHK("delta_y", 10'h255, line_delta_y)
    bus_rd(6'h34, rd);
    `CHK("dim_bad", 2'b00, rd[1:0])
    bus_wr(6'h18, 16'h6800);
    bus_rd(6'h34, rd);
    `CHK("dim_ok", 2'b10, rd[1:0])
    bus_rd(6'h18, rd);
    `CHK("x_read", 32'h00006800, rd)
    bus_wr(6'h30, 16'hC000);
    @(posedge sys_clk);
    `CHK("delta_off", 10'h000, line_delta_x)
  endtask

  task automatic t_start();
    int s0;
    s0 = starts;
    bus_wr(6'h30, 16'hC002);
    bus_wr(6'h10, 16'h4ABD);
    repeat (2) @(posedge sys_clk);
    `CHK("quick_start", s0 + 1, starts)
    bus_rd(6'h34, rd);
    `CHK("busy", 1'b1, rd[0])
    pulse_done();
    bus_rd(6'h34, rd);
    `CHK("idle", 1'b0, rd[0])
    bus_wr(6'h30, 16'hC006);
    bus_wr(6'h10, 16'h4ABD);
    repeat (2) @(posedge sys_clk);
    `CHK("no_quick", s0 + 1, starts)
    bus_wr(6'h30, 16'hC001);
    repeat (2) @(posedge sys_clk);
    `CHK("go_start", s0 + 2, starts)
    bus_rd(6'h30, rd);
    `CHK("ctrl_read", 32'h0000C000, rd)
    pulse_done();
  endtask

  task automatic t_update();
    // Forward moves only, so positions are upper-left corners
    bus_wr(6'h30, 16'hC004);
    bus_wr(6'h10, 16'h4ABD);
    bus_wr(6'h14, 16'h505A);
    bus_wr(6'h18, 16'h6010);
    bus_wr(6'h1C, 16'h7003);
    pulse_done();
    `CHK("rect_adv", POS + 21'h10, dest_pos)
    bus_wr(6'h30, 16'hC084);
    bus_wr(6'h14, 16'h51FF);
    bus_wr(6'h10, 16'h4FF0);
    pulse_done();
    `CHK("lin_wrap", 21'h000020, dest_pos)
    bus_rd(6'h10, rd);
    `CHK("low_upd", 32'h00004020, rd)
    bus_rd(6'h14, rd);
    `CHK("high_upd", 32'h00005000, rd)
    bus_wr(6'h30, 16'hC000);
    pulse_done();
    `CHK("no_upd", 21'h000020, dest_pos)
  endtask

  initial begin
    rst_n = 1'b0;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'h0;
    engine_done = 1'b0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    `CHK("pos_reset", 21'h000000, dest_pos)
    t_reset_and_pos();
    t_map();
    t_dims();
    t_start();
    t_update();
    close_out();
  end
endmodule // testbench

`default_nettype wire
